/* File: design/sdrb_defines.svh */
`ifndef SDRB_DEFINES_SVH
`define SDRB_DEFINES_SVH

`define SDRB_BANKS 8
`define SDRB_BANK_W 3
`define SDRB_ADDR_W 14
`define SDRB_DQ_W 8
`define SDRB_COL_W 10
`define SDRB_AP_BIT 10
`define SDRB_BSEL_BIT 12
`define SDRB_LAT_W 5
`define SDRB_CNT_W 6
`define SDRB_BEAT_W 4
`define SDRB_DIV_W 8
`define SDRB_CCD 6'h04
`define SDRB_BEATS_CHOP 4'h4
`define SDRB_BEATS_FULL 4'h8
`define SDRB_BL_FIXED8 2'h0
`define SDRB_BL_OTF 2'h1
`define SDRB_BL_FIXED4 2'h2
`define SDRB_TRP_CK 4
`define SDRB_RL_MAX 32
`define SDRB_AP_WAIT 48
`define SDRB_RST_HOLD 8
`define SDRB_SYNC_FALLS 3

`endif

/* File: design/sdrb_pkg.sv */
`include "sdrb_defines.svh"

package sdrb_pkg;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_WR = 3'h2,
    CMD_RD = 3'h3,
    CMD_PRE = 3'h6
  } sdrb_cmd_t;

  typedef enum logic [1:0] {
    B_IDLE = 2'h0,
    B_ACTIVE = 2'h1,
    B_PRECH = 2'h3
  } sdrb_bank_state_t;

  typedef enum logic [1:0] {
    C_READY = 2'h0,
    C_DRIVE = 2'h1,
    C_HOLD = 2'h3
  } sdrb_ctl_state_t;

  typedef struct packed {
    logic valid;
    logic full;
    logic autoPre;
    logic [`SDRB_BANK_W-1:0] bank;
    logic [`SDRB_COL_W-1:0] col;
  } sdrb_read_t;

endpackage

/* File: design/sdrb_link_if.sv */
`timescale 1ns/1ps
`include "sdrb_defines.svh"

interface sdrb_link_if;
  logic linkClk;
  logic linkRst;
  sdrb_pkg::sdrb_cmd_t cmd;
  logic [`SDRB_BANK_W-1:0] bankSelect;
  logic [`SDRB_ADDR_W-1:0] rowAddress;
  logic [`SDRB_DQ_W-1:0] dq;
  logic dqStrobe;

  modport ctl (
    output linkClk,
    output linkRst,
    output cmd,
    output bankSelect,
    output rowAddress,
    input dq,
    input dqStrobe
  );

  modport dev (
    input linkClk,
    input linkRst,
    input cmd,
    input bankSelect,
    input rowAddress,
    output dq,
    output dqStrobe
  );
endinterface

/* File: design/sdrb_device.sv */
`timescale 1ns/1ps
`include "sdrb_defines.svh"

// Summary of operation
// [R1] Activate opens addressed row in selected bank
// [R2] Row stays open until that bank's precharge
// [R3] Precharge closes one bank or all banks
// [R4] Controller waits precharge period before activating
// [R5] Other-bank column commands allowed during auto precharge
// [R6] Idle bank needs activate before read/write
// [R7] Precharge to idle/precharging bank restarts period
// [R8] Burst-select low chops four, high full eight
// [R9] Burst-select bit never part of column
// [R10] Mode field 00, or 01 with bit high: eight
// [R11] Read data starts after additive plus strobe latency
// [R12] Per-bank state checked on every activate, read and write
module sdrb_device #(
  parameter int PRECH_CYCLES = `SDRB_TRP_CK,
  parameter int RL_MAX = `SDRB_RL_MAX
) (
  sdrb_link_if.dev link,
  input wire logic [1:0] burstLenField,
  input wire logic [`SDRB_LAT_W-1:0] additiveLatency,
  input wire logic [`SDRB_LAT_W-1:0] casLatency,
  output logic [`SDRB_BANKS-1:0] bankOpen,
  output logic cmdError
);

  localparam int CFG_W = 2 + 2 * `SDRB_LAT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for reset and configuration pins

  logic rstMeta_r;
  logic rstSync_r;
  logic [CFG_W-1:0] cfgMeta_r;
  logic [CFG_W-1:0] cfgSync_r;

  always_ff @(posedge link.linkClk) begin
    rstMeta_r <= link.linkRst;
    rstSync_r <= rstMeta_r;
    cfgMeta_r <= {burstLenField, additiveLatency, casLatency};
    cfgSync_r <= cfgMeta_r;
  end

  logic [1:0] blField;
  logic [`SDRB_LAT_W:0] readLat;
  int tapIdx;

  // [R11] read latency sum
  always_comb begin
    blField = cfgSync_r[CFG_W-1 -: 2];
    readLat = {1'b0, cfgSync_r[2*`SDRB_LAT_W-1 -: `SDRB_LAT_W]}
      + {1'b0, cfgSync_r[`SDRB_LAT_W-1:0]};
    if (readLat == '0) begin
      tapIdx = 0;
    end else if (int'(readLat) > RL_MAX) begin
      tapIdx = RL_MAX - 1;
    end else begin
      tapIdx = int'(readLat) - 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // [R10] burst length from mode field and burst-select bit
  function automatic logic isFullBurst(input logic [1:0] field, input logic bsel);
    logic full;
    full = 1'b1;
    if (field == `SDRB_BL_FIXED4) begin
      full = 1'b0;
    end else if (field == `SDRB_BL_OTF) begin
      // [R8] on-the-fly choice
      full = bsel;
    end
    return full;
  endfunction

  // Sequential order, wrapping inside the nibble or the full burst
  function automatic logic [`SDRB_DQ_W-1:0] readWord(
    input logic [`SDRB_ADDR_W-1:0] row,
    input sdrb_pkg::sdrb_read_t rd,
    input logic [`SDRB_BEAT_W-1:0] beat
  );
    logic [`SDRB_COL_W-1:0] a;
    a = rd.col;
    if (rd.full) begin
      a[2:0] = rd.col[2:0] + beat[2:0];
    end else begin
      a[1:0] = rd.col[1:0] + beat[1:0];
    end
    return row[`SDRB_DQ_W-1:0] ^ a[`SDRB_DQ_W-1:0] ^ {5'h00, rd.bank};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bank state and command decode

  sdrb_pkg::sdrb_bank_state_t bankState_r [`SDRB_BANKS];
  sdrb_pkg::sdrb_bank_state_t bankState_nxt [`SDRB_BANKS];
  logic [`SDRB_ADDR_W-1:0] openRow_r [`SDRB_BANKS];
  logic [`SDRB_ADDR_W-1:0] openRow_nxt [`SDRB_BANKS];
  logic [`SDRB_CNT_W-1:0] prechCnt_r [`SDRB_BANKS];
  logic [`SDRB_CNT_W-1:0] prechCnt_nxt [`SDRB_BANKS];
  logic cmdError_r;
  logic cmdError_nxt;
  sdrb_pkg::sdrb_read_t newRead;
  sdrb_pkg::sdrb_read_t curRead_r;
  logic [`SDRB_BEAT_W-1:0] beatsLeft_r;
  logic dqStrobe_r;

  always_comb begin
    logic [`SDRB_BANK_W-1:0] sel;
    sel = link.bankSelect;
    bankState_nxt = bankState_r;
    openRow_nxt = openRow_r;
    prechCnt_nxt = prechCnt_r;
    cmdError_nxt = 1'b0;
    newRead = '0;
    // [R4] precharge period countdown, then idle
    for (int b = 0; b < `SDRB_BANKS; b++) begin
      if (bankState_r[b] == sdrb_pkg::B_PRECH) begin
        if (prechCnt_r[b] <= `SDRB_CNT_W'(1)) begin
          bankState_nxt[b] = sdrb_pkg::B_IDLE;
          prechCnt_nxt[b] = '0;
        end else begin
          prechCnt_nxt[b] = prechCnt_r[b] - `SDRB_CNT_W'(1);
        end
      end
    end
    // [R5] read auto precharge begins when its burst has left the pins; write auto precharge begins at the command
    if (dqStrobe_r && beatsLeft_r == '0 && curRead_r.autoPre) begin
      bankState_nxt[curRead_r.bank] = sdrb_pkg::B_PRECH;
      prechCnt_nxt[curRead_r.bank] = `SDRB_CNT_W'(PRECH_CYCLES);
    end
    unique case (link.cmd)
      sdrb_pkg::CMD_NOP: begin
      end
      sdrb_pkg::CMD_ACT: begin
        // [R12] activate only an idle bank
        if (bankState_r[sel] == sdrb_pkg::B_IDLE) begin
          // [R1] open the addressed row
          bankState_nxt[sel] = sdrb_pkg::B_ACTIVE;
          openRow_nxt[sel] = link.rowAddress;
        end else begin
          // [R2] any open row, same or different, or a running precharge rejects the activate
          cmdError_nxt = 1'b1;
        end
      end
      sdrb_pkg::CMD_PRE: begin
        // [R3] one bank or all banks
        for (int b = 0; b < `SDRB_BANKS; b++) begin
          if (link.rowAddress[`SDRB_AP_BIT] || sel == `SDRB_BANK_W'(b)) begin
            // [R7] latest precharge restarts the period
            bankState_nxt[b] = sdrb_pkg::B_PRECH;
            prechCnt_nxt[b] = `SDRB_CNT_W'(PRECH_CYCLES);
          end
        end
      end
      sdrb_pkg::CMD_RD,
      sdrb_pkg::CMD_WR: begin
        // [R6] column commands need an active bank
        if (bankState_r[sel] != sdrb_pkg::B_ACTIVE) begin
          cmdError_nxt = 1'b1;
        end else if (link.cmd == sdrb_pkg::CMD_RD) begin
          newRead.valid = 1'b1;
          newRead.full = isFullBurst(blField, link.rowAddress[`SDRB_BSEL_BIT]);
          newRead.autoPre = link.rowAddress[`SDRB_AP_BIT];
          newRead.bank = sel;
          // [R9] column from low bits only
          newRead.col = link.rowAddress[`SDRB_COL_W-1:0];
        end else if (link.rowAddress[`SDRB_AP_BIT]) begin
          bankState_nxt[sel] = sdrb_pkg::B_PRECH;
          prechCnt_nxt[sel] = `SDRB_CNT_W'(PRECH_CYCLES);
        end
      end
      default: begin
        cmdError_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge link.linkClk) begin
    if (rstSync_r) begin
      for (int b = 0; b < `SDRB_BANKS; b++) begin
        bankState_r[b] <= sdrb_pkg::B_IDLE;
        openRow_r[b] <= '0;
        prechCnt_r[b] <= '0;
      end
      cmdError_r <= 1'b0;
    end else begin
      bankState_r <= bankState_nxt;
      openRow_r <= openRow_nxt;
      prechCnt_r <= prechCnt_nxt;
      cmdError_r <= cmdError_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read latency pipe and burst output

  sdrb_pkg::sdrb_read_t readPipe_r [RL_MAX];
  sdrb_pkg::sdrb_read_t readPipe_nxt [RL_MAX];
  sdrb_pkg::sdrb_read_t curRead_nxt;
  sdrb_pkg::sdrb_read_t tapRead;
  logic [`SDRB_BEAT_W-1:0] beatsLeft_nxt;
  logic [`SDRB_BEAT_W-1:0] beatIdx_r;
  logic [`SDRB_BEAT_W-1:0] beatIdx_nxt;
  logic [`SDRB_DQ_W-1:0] dq_r;
  logic [`SDRB_DQ_W-1:0] dq_nxt;
  logic dqStrobe_nxt;

  always_comb begin
    readPipe_nxt[0] = newRead;
    for (int k = 1; k < RL_MAX; k++) begin
      readPipe_nxt[k] = readPipe_r[k-1];
    end
    tapRead = readPipe_r[tapIdx];
    curRead_nxt = curRead_r;
    beatsLeft_nxt = beatsLeft_r;
    beatIdx_nxt = beatIdx_r;
    dq_nxt = dq_r;
    dqStrobe_nxt = 1'b0;
    // [R11] first beat at read latency after the command
    if (tapRead.valid) begin
      curRead_nxt = tapRead;
      beatIdx_nxt = '0;
      // [R8] chopped four or full eight beats
      beatsLeft_nxt = (tapRead.full ? `SDRB_BEATS_FULL : `SDRB_BEATS_CHOP)
        - `SDRB_BEAT_W'(1);
      dq_nxt = readWord(openRow_r[tapRead.bank], tapRead, '0);
      dqStrobe_nxt = 1'b1;
    end else if (beatsLeft_r != '0) begin
      beatIdx_nxt = beatIdx_r + `SDRB_BEAT_W'(1);
      beatsLeft_nxt = beatsLeft_r - `SDRB_BEAT_W'(1);
      dq_nxt = readWord(openRow_r[curRead_r.bank], curRead_r, beatIdx_nxt);
      dqStrobe_nxt = 1'b1;
    end
  end

  always_ff @(posedge link.linkClk) begin
    if (rstSync_r) begin
      for (int k = 0; k < RL_MAX; k++) begin
        readPipe_r[k] <= '0;
      end
      curRead_r <= '0;
      beatsLeft_r <= '0;
      beatIdx_r <= '0;
      dq_r <= '0;
      dqStrobe_r <= 1'b0;
    end else begin
      readPipe_r <= readPipe_nxt;
      curRead_r <= curRead_nxt;
      beatsLeft_r <= beatsLeft_nxt;
      beatIdx_r <= beatIdx_nxt;
      dq_r <= dq_nxt;
      dqStrobe_r <= dqStrobe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [`SDRB_BANKS-1:0] bankOpen_r;

  always_ff @(posedge link.linkClk) begin
    for (int b = 0; b < `SDRB_BANKS; b++) begin
      bankOpen_r[b] <= !rstSync_r && bankState_nxt[b] == sdrb_pkg::B_ACTIVE;
    end
  end

  assign bankOpen = bankOpen_r;
  assign cmdError = cmdError_r;
  assign link.dq = dq_r;
  assign link.dqStrobe = dqStrobe_r;

endmodule

/* File: design/sdrb_controller.sv */
`timescale 1ns/1ps
`include "sdrb_defines.svh"

module sdrb_controller #(
  parameter int DIV_HALF = 1,
  parameter int PRECH_CYCLES = `SDRB_TRP_CK,
  parameter int AP_WAIT = `SDRB_AP_WAIT,
  parameter int RST_HOLD = `SDRB_RST_HOLD
) (
  input wire logic clk,
  input wire logic rst,
  sdrb_link_if.ctl link,
  input wire logic reqValid,
  output logic reqReady,
  input wire sdrb_pkg::sdrb_cmd_t reqCmd,
  input wire logic [`SDRB_BANK_W-1:0] reqBank,
  input wire logic [`SDRB_ADDR_W-1:0] reqAddr,
  output logic reqError,
  output logic [`SDRB_DQ_W-1:0] rdData,
  output logic rdValid
);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider and link reset stretch

  logic [`SDRB_DIV_W-1:0] divCnt_r;
  logic [`SDRB_DIV_W-1:0] divCnt_nxt;
  logic linkClk_r;
  logic linkClk_nxt;
  logic linkRst_r;
  logic linkRst_nxt;
  logic [`SDRB_CNT_W-1:0] holdCnt_r;
  logic [`SDRB_CNT_W-1:0] holdCnt_nxt;
  logic toggle;
  logic riseTick;
  logic fallTick;
  logic linkUp;

  always_comb begin
    toggle = divCnt_r == `SDRB_DIV_W'(DIV_HALF - 1);
    riseTick = toggle && !linkClk_r;
    fallTick = toggle && linkClk_r;
    divCnt_nxt = toggle ? '0 : divCnt_r + `SDRB_DIV_W'(1);
    linkClk_nxt = linkClk_r ^ toggle;
    linkUp = holdCnt_r == `SDRB_CNT_W'(RST_HOLD + `SDRB_SYNC_FALLS);
    linkRst_nxt = linkRst_r;
    holdCnt_nxt = holdCnt_r;
    // Release on a falling link edge, then let the device reset sync drain
    if (fallTick && !linkUp) begin
      holdCnt_nxt = holdCnt_r + `SDRB_CNT_W'(1);
      if (holdCnt_r == `SDRB_CNT_W'(RST_HOLD - 1)) begin
        linkRst_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt_r <= '0;
      linkClk_r <= 1'b0;
      linkRst_r <= 1'b1;
      holdCnt_r <= '0;
    end else begin
      divCnt_r <= divCnt_nxt;
      linkClk_r <= linkClk_nxt;
      linkRst_r <= linkRst_nxt;
      holdCnt_r <= holdCnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request check, bank bookkeeping and command drive

  sdrb_pkg::sdrb_ctl_state_t state_r;
  sdrb_pkg::sdrb_ctl_state_t state_nxt;
  logic open_r [`SDRB_BANKS];
  logic open_nxt [`SDRB_BANKS];
  logic [`SDRB_CNT_W-1:0] wait_r [`SDRB_BANKS];
  logic [`SDRB_CNT_W-1:0] wait_nxt [`SDRB_BANKS];
  logic [`SDRB_CNT_W-1:0] gap_r;
  logic [`SDRB_CNT_W-1:0] gap_nxt;
  sdrb_pkg::sdrb_cmd_t heldCmd_r;
  sdrb_pkg::sdrb_cmd_t heldCmd_nxt;
  logic [`SDRB_BANK_W-1:0] heldBank_r;
  logic [`SDRB_BANK_W-1:0] heldBank_nxt;
  logic [`SDRB_ADDR_W-1:0] heldAddr_r;
  logic [`SDRB_ADDR_W-1:0] heldAddr_nxt;
  sdrb_pkg::sdrb_cmd_t cmd_r;
  sdrb_pkg::sdrb_cmd_t cmd_nxt;
  logic [`SDRB_BANK_W-1:0] bank_r;
  logic [`SDRB_BANK_W-1:0] bank_nxt;
  logic [`SDRB_ADDR_W-1:0] addr_r;
  logic [`SDRB_ADDR_W-1:0] addr_nxt;
  logic reqError_nxt;
  logic reqError_r;
  logic illegal;
  logic blocked;
  logic take;

  always_comb begin
    illegal = 1'b0;
    blocked = 1'b0;
    unique case (reqCmd)
      sdrb_pkg::CMD_NOP,
      sdrb_pkg::CMD_PRE: begin
      end
      sdrb_pkg::CMD_ACT: begin
        // [R2] no activate over an open row
        illegal = open_r[reqBank];
        // [R4] hold activate until precharge period is over
        blocked = wait_r[reqBank] != '0;
      end
      sdrb_pkg::CMD_RD,
      sdrb_pkg::CMD_WR: begin
        // [R6] column command only to an activated bank
        illegal = !open_r[reqBank];
        // [R5] keep four-cycle column spacing so chopped bursts are not cut
        blocked = gap_r != '0;
      end
      default: begin
        illegal = 1'b1;
      end
    endcase
    reqReady = state_r == sdrb_pkg::C_READY && linkUp && !blocked;
    take = reqValid && reqReady;
  end

  always_comb begin
    state_nxt = state_r;
    open_nxt = open_r;
    wait_nxt = wait_r;
    gap_nxt = gap_r;
    heldCmd_nxt = heldCmd_r;
    heldBank_nxt = heldBank_r;
    heldAddr_nxt = heldAddr_r;
    cmd_nxt = cmd_r;
    bank_nxt = bank_r;
    addr_nxt = addr_r;
    reqError_nxt = 1'b0;
    if (riseTick) begin
      for (int b = 0; b < `SDRB_BANKS; b++) begin
        if (wait_r[b] != '0) begin
          wait_nxt[b] = wait_r[b] - `SDRB_CNT_W'(1);
        end
      end
      if (gap_r != '0) begin
        gap_nxt = gap_r - `SDRB_CNT_W'(1);
      end
    end
    unique case (state_r)
      sdrb_pkg::C_READY: begin
        if (take && illegal) begin
          reqError_nxt = 1'b1;
        end else if (take) begin
          heldCmd_nxt = reqCmd;
          heldBank_nxt = reqBank;
          heldAddr_nxt = reqAddr;
          state_nxt = sdrb_pkg::C_DRIVE;
          if (reqCmd == sdrb_pkg::CMD_ACT) begin
            // [R1] bank and row go out with the activate
            open_nxt[reqBank] = 1'b1;
          end
          for (int b = 0; b < `SDRB_BANKS; b++) begin
            if (reqCmd == sdrb_pkg::CMD_PRE
                && (reqAddr[`SDRB_AP_BIT] || reqBank == `SDRB_BANK_W'(b))) begin
              open_nxt[b] = 1'b0;
            end
          end
          if ((reqCmd == sdrb_pkg::CMD_RD || reqCmd == sdrb_pkg::CMD_WR)
              && reqAddr[`SDRB_AP_BIT]) begin
            open_nxt[reqBank] = 1'b0;
          end
        end
      end
      sdrb_pkg::C_DRIVE: begin
        if (fallTick) begin
          cmd_nxt = heldCmd_r;
          bank_nxt = heldBank_r;
          addr_nxt = heldAddr_r;
          state_nxt = sdrb_pkg::C_HOLD;
          for (int b = 0; b < `SDRB_BANKS; b++) begin
            if (heldCmd_r == sdrb_pkg::CMD_PRE
                && (heldAddr_r[`SDRB_AP_BIT] || heldBank_r == `SDRB_BANK_W'(b))) begin
              wait_nxt[b] = `SDRB_CNT_W'(PRECH_CYCLES);
            end
          end
          if (heldCmd_r == sdrb_pkg::CMD_RD || heldCmd_r == sdrb_pkg::CMD_WR) begin
            // [R8] spacing after every column command
            gap_nxt = `SDRB_CCD;
            if (heldAddr_r[`SDRB_AP_BIT]) begin
              wait_nxt[heldBank_r] = `SDRB_CNT_W'(AP_WAIT);
            end
          end
        end
      end
      sdrb_pkg::C_HOLD: begin
        if (fallTick) begin
          cmd_nxt = sdrb_pkg::CMD_NOP;
          state_nxt = sdrb_pkg::C_READY;
        end
      end
      default: begin
        state_nxt = sdrb_pkg::C_READY;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= sdrb_pkg::C_READY;
      for (int b = 0; b < `SDRB_BANKS; b++) begin
        open_r[b] <= 1'b0;
        wait_r[b] <= '0;
      end
      gap_r <= '0;
      heldCmd_r <= sdrb_pkg::CMD_NOP;
      heldBank_r <= '0;
      heldAddr_r <= '0;
      cmd_r <= sdrb_pkg::CMD_NOP;
      bank_r <= '0;
      addr_r <= '0;
      reqError_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      open_r <= open_nxt;
      wait_r <= wait_nxt;
      gap_r <= gap_nxt;
      heldCmd_r <= heldCmd_nxt;
      heldBank_r <= heldBank_nxt;
      heldAddr_r <= heldAddr_nxt;
      cmd_r <= cmd_nxt;
      bank_r <= bank_nxt;
      addr_r <= addr_nxt;
      reqError_r <= reqError_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data capture, half a link period after launch

  logic [`SDRB_DQ_W-1:0] rdData_r;
  logic rdValid_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_r <= '0;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= fallTick && link.dqStrobe;
      if (fallTick && link.dqStrobe) begin
        rdData_r <= link.dq;
      end
    end
  end

  assign link.linkClk = linkClk_r;
  assign link.linkRst = linkRst_r;
  assign link.cmd = cmd_r;
  assign link.bankSelect = bank_r;
  assign link.rowAddress = addr_r;
  assign reqError = reqError_r;
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;

endmodule

/* File: bench/sdrb_properties.sv */
`timescale 1ns/1ps
module sdrb_properties (
  input wire logic linkClk,
  input wire logic linkRst,
  input wire sdrb_pkg::sdrb_cmd_t cmd,
  input wire logic [2:0] bankSelect,
  input wire logic [13:0] rowAddress,
  input wire logic [7:0] dq,
  input wire logic dqStrobe,
  input wire logic [1:0] burstLenField,
  input wire logic [7:0] bankOpen
);
  logic [7:0] openMask_r;
  logic [7:0] openMask_nxt;
  logic [7:0] rowLow_r [8];
  logic [7:0] firstExp_r;
  logic [2:0] preBank_r;
  logic preAll_r;
  wire logic isRd = cmd == sdrb_pkg::CMD_RD;
  wire logic isAct = cmd == sdrb_pkg::CMD_ACT;
  wire logic isPre = cmd == sdrb_pkg::CMD_PRE;
  wire logic fullSel = burstLenField != 2'h2 && (burstLenField != 2'h1 || rowAddress[12]);

  ////////////////////////////////////////////////////////////////
  // Per-bank open tracking
  always_comb begin
    openMask_nxt = openMask_r;
    if (isAct) begin
      openMask_nxt[bankSelect] = 1'b1;
    end
    if (isPre && rowAddress[10]) begin
      openMask_nxt = 8'h00;
    end else if (isPre || ((isRd || cmd == sdrb_pkg::CMD_WR) && rowAddress[10])) begin
      openMask_nxt[bankSelect] = 1'b0;
    end
  end

  always_ff @(posedge linkClk) begin
    openMask_r <= linkRst ? 8'h00 : openMask_nxt;
    if (isAct) begin
      rowLow_r[bankSelect] <= rowAddress[7:0];
    end
    if (isRd) begin
      firstExp_r <= rowLow_r[bankSelect] ^ rowAddress[7:0] ^ {5'h00, bankSelect};
    end
    if (isPre) begin
      preBank_r <= bankSelect;
      preAll_r <= rowAddress[10];
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge linkClk);
  endclocking
  default disable iff (linkRst);

  sequence rdStart;
    isRd && !dqStrobe;
  endsequence
  sequence firstBeat;
    !dqStrobe[*3] ##1 dqStrobe;
  endsequence
  property fullBurst;
    rdStart ##0 fullSel |=> firstBeat ##1 dqStrobe[*7] ##1 !dqStrobe;
  endproperty
  property chopBurst;
    rdStart ##0 !fullSel |=> firstBeat ##1 dqStrobe[*3] ##1 (!dqStrobe || $past(isRd, 4));
  endproperty
  property preWait;
    isPre |=> (!isAct || (!preAll_r && bankSelect != preBank_r))[*3];
  endproperty

  AST_FIRST_BEAT: assert property (rdStart |=> firstBeat ##0 (dq == firstExp_r))
    else $error("first read beat late or wrong");
  AST_FULL_BURST: assert property (fullBurst)
    else $error("full burst not eight beats");
  AST_CHOP_BURST: assert property (chopBurst)
    else $error("chopped burst not four beats");
  AST_ACT_CLOSED: assert property (isAct |-> !openMask_r[bankSelect])
    else $error("activate sent to open bank");
  AST_COL_OPEN: assert property ((isRd || cmd == sdrb_pkg::CMD_WR) |-> openMask_r[bankSelect])
    else $error("column command to closed bank");
  AST_PRE_WAIT: assert property (preWait)
    else $error("activate inside precharge period");
  AST_PRE_CLOSES: assert property (isPre |-> ##[2:6] (preAll_r ? bankOpen == 8'h00 : !bankOpen[preBank_r]))
    else $error("precharge left bank open");
  AST_ACT_OPENS: assert property (isAct |=> bankOpen[$past(bankSelect)])
    else $error("activate did not open bank");
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  sdrb_pkg::sdrb_cmd_t reqCmd = sdrb_pkg::CMD_NOP;
  logic [2:0] reqBank = 3'h0;
  logic [13:0] reqAddr = 14'h0000;
  logic [1:0] burstLenField = 2'h1;
  logic reqReady;
  logic reqError;
  logic rdValid;
  logic cmdError;
  logic [7:0] rdData;
  logic [7:0] bankOpen;
  logic cmdSeen = 1'b0;
  logic [7:0] beats [$];
  int failCount = 0;
  int checkCount = 0;

  sdrb_link_if link ();
  sdrb_controller i_sdrb_controller (.clk(clk), .rst(rst), .link(link), .reqValid(reqValid),
    .reqReady(reqReady), .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr),
    .reqError(reqError), .rdData(rdData), .rdValid(rdValid));
  sdrb_device i_sdrb_device (.link(link), .burstLenField(burstLenField),
    .additiveLatency(5'h01), .casLatency(5'h02), .bankOpen(bankOpen), .cmdError(cmdError));
  sdrb_properties i_sdrb_properties (.linkClk(link.linkClk), .linkRst(link.linkRst),
    .cmd(link.cmd), .bankSelect(link.bankSelect), .rowAddress(link.rowAddress), .dq(link.dq),
    .dqStrobe(link.dqStrobe), .burstLenField(burstLenField), .bankOpen(bankOpen));

  always #50 clk = ~clk;

  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      beats.push_back(rdData);
    end
    if (cmdError === 1'b1) begin
      cmdSeen = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input sdrb_pkg::sdrb_cmd_t c, input logic [2:0] b, input logic [13:0] a,
                      input logic err);
    int n;
    @(negedge clk);
    reqValid = 1'b1;
    reqCmd = c;
    reqBank = b;
    reqAddr = a;
    n = 0;
    #1;
    while (reqReady !== 1'b1 && n < 3000) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n == 3000) begin
      failCount++;
      closeOut();
    end
    @(posedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    check({7'h00, reqError}, {7'h00, err});
  endtask

  task automatic waitBeats(input int n);
    int k;
    k = 0;
    while (beats.size() < n && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (k == 300) begin
      failCount++;
      closeOut();
    end
    repeat (20) @(negedge clk);
    check(8'(beats.size()), 8'(n));
  endtask

  task automatic readBurst(input logic [2:0] b, input logic [13:0] a, input logic [7:0] row,
                           input int n);
    beats.delete();
    send(sdrb_pkg::CMD_RD, b, a, 1'b0);
    waitBeats(n);
    for (int k = 0; k < n; k++) begin
      check(beats[k], row ^ (a[7:0] + 8'(k)) ^ {5'h00, b});
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    send(sdrb_pkg::CMD_ACT, 3'h5, 14'h2a5c, 1'b0);
    for (int f = 0; f < 8; f++) begin
      @(negedge clk);
      burstLenField = 2'(f >> 1);
      repeat (8) @(negedge clk);
      readBurst(3'h5, f[0] ? 14'h31c8 : 14'h21c8, 8'h5c, (f == 2 || f == 4 || f == 5) ? 4 : 8);
    end
    $display("test burst lengths done");
    send(sdrb_pkg::CMD_ACT, 3'h5, 14'h0111, 1'b1);
    send(sdrb_pkg::CMD_RD, 3'h2, 14'h0000, 1'b1);
    $display("test bank state done");
    send(sdrb_pkg::CMD_PRE, 3'h5, 14'h0000, 1'b0);
    send(sdrb_pkg::CMD_PRE, 3'h5, 14'h0000, 1'b0);
    send(sdrb_pkg::CMD_RD, 3'h5, 14'h0000, 1'b1);
    send(sdrb_pkg::CMD_ACT, 3'h5, 14'h1234, 1'b0);
    send(sdrb_pkg::CMD_ACT, 3'h1, 14'h0077, 1'b0);
    repeat (8) @(negedge clk);
    check(bankOpen, 8'h22);
    send(sdrb_pkg::CMD_PRE, 3'h0, 14'h0400, 1'b0);
    repeat (20) @(negedge clk);
    check(bankOpen, 8'h00);
    send(sdrb_pkg::CMD_RD, 3'h1, 14'h0000, 1'b1);
    $display("test precharge done");
    burstLenField = 2'h1;
    send(sdrb_pkg::CMD_ACT, 3'h3, 14'h0033, 1'b0);
    send(sdrb_pkg::CMD_ACT, 3'h4, 14'h0044, 1'b0);
    beats.delete();
    send(sdrb_pkg::CMD_RD, 3'h3, 14'h0408, 1'b0);
    send(sdrb_pkg::CMD_RD, 3'h4, 14'h0010, 1'b0);
    waitBeats(8);
    for (int k = 0; k < 4; k++) begin
      check(beats[k], 8'h33 ^ (8'h08 + 8'(k)) ^ 8'h03);
      check(beats[k + 4], 8'h44 ^ (8'h10 + 8'(k)) ^ 8'h04);
    end
    send(sdrb_pkg::CMD_RD, 3'h3, 14'h0000, 1'b1);
    send(sdrb_pkg::CMD_WR, 3'h4, 14'h0400, 1'b0);
    send(sdrb_pkg::CMD_RD, 3'h4, 14'h0000, 1'b1);
    repeat (8) @(negedge clk);
    check(bankOpen, 8'h00);
    check({7'h00, cmdSeen}, 8'h00);
    $display("test auto precharge done");
    closeOut();
  end
endmodule
